// ### rtc_consts.vh
// Overview of operation
// - Keep a 24-bit up-counter and a 12-bit prescale divider.
// - Count rate is slow clock divided by prescaler setting plus one.
// - Prescaler writable only while stopped; writes while running are ignored.
// - Start, clear and force-wrap reload the prescale countdown from the setting.
// - Counter steps on a slow edge when countdown is zero, then countdown reloads.
// - Tick event on every increment when routed; routing off after reset.
// - Force-wrap task loads the counter with 0xfffff0.
// - Wrap event on roll from 0xffffff to zero; routing off after reset.
// - Each event has its own route enable; unrouted events request no clock.
// - Clear never makes a compare event on a compare value of zero.
// - Start never makes a compare event when counter already equals compare value.
// - Compare event when counter steps from value minus one to the value.
// - Compare value two or more above count always hits when reached.
// - Compare value equal or one above the count may miss.
// - An old compare value more than two above the count never matches.
// - Counting runs from slow clock edges sampled on the fast clock while enabled, without bus activity.
// - Clear, stop and force-wrap act after a falling then rising slow edge.
// - A counter read holds the bus three cycles while the count is sampled.
// - Number of compare channels is a parameter, three or four.
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

`define RTC_OFS_TASK_START 12'h000
`define RTC_OFS_TASK_STOP 12'h004
`define RTC_OFS_TASK_CLEAR 12'h008
`define RTC_OFS_TASK_WRAP 12'h00c
`define RTC_OFS_EV_TICK 12'h100
`define RTC_OFS_EV_WRAP 12'h104
`define RTC_PAGE_CMP_EV 8'h14
`define RTC_OFS_ROUTE 12'h340
`define RTC_OFS_ROUTE_SET 12'h344
`define RTC_OFS_ROUTE_CLR 12'h348
`define RTC_OFS_COUNT 12'h504
`define RTC_OFS_PRESCALE 12'h508
`define RTC_PAGE_CMP_VAL 8'h54

`define RTC_BIT_TICK 0
`define RTC_BIT_WRAP 1
`define RTC_BIT_CMP0 16

`define RTC_CNT_W 24
`define RTC_PRE_W 12
`define RTC_NEAR_WRAP 24'hfffff0
`define RTC_CNT_MAX 24'hffffff
`define RTC_HOLD_CYCLES 2'h3

`endif

// ### rtc_compare_chan.v
`timescale 1ns/1ps
`include "rtc_consts.vh"
module rtc_compare_chan #(
   parameter CNT_W = `RTC_CNT_W
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   // Value write
   input wire i_wr,
   input wire [CNT_W-1:0] i_wdata,
   // Counter step
   input wire i_step,
   input wire [CNT_W-1:0] i_cnt_next,
   // Results
   output wire [CNT_W-1:0] o_value,
   output wire o_hit
);
   reg [CNT_W-1:0] value_ff;

   // New value replaces the old on the write's clock edge, so a stale value can match only in the write cycle
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         value_ff <= {CNT_W{1'b0}};
      end else if (i_ce && i_wr) begin
         value_ff <= i_wdata;
      end
   end

   // Only a real increment matches; clear, start and force-wrap never do
   assign o_hit = i_step && (i_cnt_next == value_ff);
   assign o_value = value_ff;
endmodule // rtc_compare_chan

// ### rtc_counter.v
`timescale 1ns/1ps
`include "rtc_consts.vh"
module rtc_counter #(
   parameter N_CMP = 4,
   parameter CNT_W = `RTC_CNT_W,
   parameter PRE_W = `RTC_PRE_W
) (
   // Clock, reset, enable
   input wire I_MCLK,
   input wire I_RST,
   input wire I_CE,
   // Slow clock, sampled as a level
   input wire I_SLOW_CLK,
   // Register port
   input wire [11:0] I_ADDR,
   input wire [31:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [31:0] O_RDATA,
   output reg O_BUS_HOLD,
   // Routed events, clock request and run state
   output reg O_EVT_TICK,
   output reg O_EVT_WRAP,
   output reg [N_CMP-1:0] O_EVT_CMP,
   output reg O_CLK_REQ,
   output reg O_RUNNING
);
   reg slow_ff;
   reg [3:0] pend_ff;
   reg armed_ff;
   reg run_ff;
   reg [CNT_W-1:0] cnt_ff;
   reg [PRE_W-1:0] pre_set_ff;
   reg [PRE_W-1:0] pre_cnt_ff;
   reg ev_tick_ff;
   reg ev_wrap_ff;
   reg [N_CMP-1:0] ev_cmp_ff;
   reg [31:0] route_ff;
   reg [1:0] hold_ff;

   reg [3:0] nxt_pend;
   reg nxt_armed;
   reg nxt_run;
   reg [CNT_W-1:0] nxt_cnt;
   reg [PRE_W-1:0] nxt_pre_cnt;
   reg step;
   reg [31:0] rd_mux;

   wire slow_rise;
   wire slow_fall;
   wire [3:0] task_wr;
   wire [3:0] apply;
   wire cmp_ev_page;
   wire cmp_val_page;
   wire [N_CMP-1:0] cmp_hit;
   wire [N_CMP-1:0] cmp_wr;
   wire [N_CMP*CNT_W-1:0] cmp_vals;
   wire wrap_hit;
   wire [N_CMP-1:0] cmp_route;
   wire [N_CMP-1:0] cmp_ev_wr;

   localparam T_START = 0;
   localparam T_STOP = 1;
   localparam T_CLEAR = 2;
   localparam T_WRAP = 3;

   // Counting needs slow clock edges sampled on the fast clock while enabled, never the register port
   assign slow_rise = I_SLOW_CLK && !slow_ff;
   assign slow_fall = !I_SLOW_CLK && slow_ff;

   assign task_wr[T_START] = I_WR && (I_ADDR == `RTC_OFS_TASK_START) && I_WDATA[0];
   assign task_wr[T_STOP] = I_WR && (I_ADDR == `RTC_OFS_TASK_STOP) && I_WDATA[0];
   assign task_wr[T_CLEAR] = I_WR && (I_ADDR == `RTC_OFS_TASK_CLEAR) && I_WDATA[0];
   assign task_wr[T_WRAP] = I_WR && (I_ADDR == `RTC_OFS_TASK_WRAP) && I_WDATA[0];

   // Tasks act on a rising slow edge after a falling one was seen
   assign apply = (slow_rise && armed_ff) ? pend_ff : 4'h0;

   assign cmp_ev_page = (I_ADDR[11:4] == `RTC_PAGE_CMP_EV) && (I_ADDR[1:0] == 2'h0);
   assign cmp_val_page = (I_ADDR[11:4] == `RTC_PAGE_CMP_VAL) && (I_ADDR[1:0] == 2'h0);
   assign wrap_hit = step && (cnt_ff == `RTC_CNT_MAX);
   assign cmp_route = route_ff[`RTC_BIT_CMP0 +: N_CMP];

   genvar g;
   generate
      for (g = 0; g < N_CMP; g = g + 1) begin : g_cmp
         assign cmp_wr[g] = I_WR && cmp_val_page && (I_ADDR[3:2] == g);
         assign cmp_ev_wr[g] = I_WR && cmp_ev_page && (I_ADDR[3:2] == g) && !I_WDATA[0];
         rtc_compare_chan #(
            .CNT_W(CNT_W)
         ) u_chan (
            .i_clk(I_MCLK),
            .i_rst(I_RST),
            .i_ce(I_CE),
            .i_wr(cmp_wr[g]),
            .i_wdata(I_WDATA[CNT_W-1:0]),
            .i_step(step),
            .i_cnt_next(nxt_cnt),
            .o_value(cmp_vals[g*CNT_W +: CNT_W]),
            .o_hit(cmp_hit[g])
         );
      end
   endgenerate

   // Task sequencing and the slow-domain count
   always @* begin
      nxt_pend = (pend_ff & ~apply) | task_wr;
      nxt_armed = armed_ff;
      if (|apply) begin
         nxt_armed = 1'b0;
      end else if (slow_fall && (|pend_ff)) begin
         nxt_armed = 1'b1;
      end
      nxt_run = run_ff;
      if (apply[T_START]) begin
         nxt_run = 1'b1;
      end
      if (apply[T_STOP]) begin
         nxt_run = 1'b0;
      end
      nxt_cnt = cnt_ff;
      nxt_pre_cnt = pre_cnt_ff;
      step = 1'b0;
      if (slow_rise && run_ff && !apply[T_STOP]) begin
         if (pre_cnt_ff == {PRE_W{1'b0}}) begin
            step = 1'b1;
            nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            nxt_pre_cnt = pre_set_ff;
         end else begin
            nxt_pre_cnt = pre_cnt_ff - {{(PRE_W-1){1'b0}}, 1'b1};
         end
      end
      if (apply[T_START] || apply[T_CLEAR] || apply[T_WRAP]) begin
         nxt_pre_cnt = pre_set_ff;
      end
      if (apply[T_CLEAR]) begin
         step = 1'b0;
         nxt_cnt = {CNT_W{1'b0}};
      end
      if (apply[T_WRAP]) begin
         step = 1'b0;
         nxt_cnt = `RTC_NEAR_WRAP;
      end
   end

   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         slow_ff <= 1'b0;
         pend_ff <= 4'h0;
         armed_ff <= 1'b0;
         run_ff <= 1'b0;
         cnt_ff <= {CNT_W{1'b0}};
         pre_cnt_ff <= {PRE_W{1'b0}};
         pre_set_ff <= {PRE_W{1'b0}};
         O_RUNNING <= 1'b0;
      end else if (I_CE) begin
         slow_ff <= I_SLOW_CLK;
         pend_ff <= nxt_pend;
         armed_ff <= nxt_armed;
         run_ff <= nxt_run;
         cnt_ff <= nxt_cnt;
         pre_cnt_ff <= nxt_pre_cnt;
         O_RUNNING <= nxt_run;
         if (I_WR && (I_ADDR == `RTC_OFS_PRESCALE) && !run_ff) begin
            pre_set_ff <= I_WDATA[PRE_W-1:0];
         end
      end
   end

   // Sticky event flags: a new event wins over a software clear
   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         ev_tick_ff <= 1'b0;
         ev_wrap_ff <= 1'b0;
         ev_cmp_ff <= {N_CMP{1'b0}};
      end else if (I_CE) begin
         if (step) begin
            ev_tick_ff <= 1'b1;
         end else if (I_WR && (I_ADDR == `RTC_OFS_EV_TICK) && !I_WDATA[0]) begin
            ev_tick_ff <= 1'b0;
         end
         if (wrap_hit) begin
            ev_wrap_ff <= 1'b1;
         end else if (I_WR && (I_ADDR == `RTC_OFS_EV_WRAP) && !I_WDATA[0]) begin
            ev_wrap_ff <= 1'b0;
         end
         ev_cmp_ff <= (ev_cmp_ff & ~cmp_ev_wr) | cmp_hit;
      end
   end

   // Routing enables, cleared at reset so no event is routed
   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         route_ff <= 32'h00000000;
      end else if (I_CE && I_WR) begin
         if (I_ADDR == `RTC_OFS_ROUTE) begin
            route_ff <= I_WDATA;
         end else if (I_ADDR == `RTC_OFS_ROUTE_SET) begin
            route_ff <= route_ff | I_WDATA;
         end else if (I_ADDR == `RTC_OFS_ROUTE_CLR) begin
            route_ff <= route_ff & ~I_WDATA;
         end
      end
   end

   // Routed event pulses; only routed events ask for the fast clocks
   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_EVT_TICK <= 1'b0;
         O_EVT_WRAP <= 1'b0;
         O_EVT_CMP <= {N_CMP{1'b0}};
         O_CLK_REQ <= 1'b0;
      end else if (I_CE) begin
         O_EVT_TICK <= step && route_ff[`RTC_BIT_TICK];
         O_EVT_WRAP <= wrap_hit && route_ff[`RTC_BIT_WRAP];
         O_EVT_CMP <= cmp_hit & cmp_route;
         O_CLK_REQ <= (step && route_ff[`RTC_BIT_TICK]) ||
                      (wrap_hit && route_ff[`RTC_BIT_WRAP]) ||
                      (|(cmp_hit & cmp_route));
      end
   end

   // Read data and the bus hold that follows a counter read
   always @* begin
      rd_mux = 32'h00000000;
      if (I_ADDR == `RTC_OFS_EV_TICK) begin
         rd_mux[0] = ev_tick_ff;
      end else if (I_ADDR == `RTC_OFS_EV_WRAP) begin
         rd_mux[0] = ev_wrap_ff;
      end else if (cmp_ev_page && (I_ADDR[3:2] < N_CMP)) begin
         rd_mux[0] = ev_cmp_ff[I_ADDR[3:2]];
      end else if ((I_ADDR == `RTC_OFS_ROUTE) || (I_ADDR == `RTC_OFS_ROUTE_SET) ||
                   (I_ADDR == `RTC_OFS_ROUTE_CLR)) begin
         rd_mux[`RTC_BIT_TICK] = route_ff[`RTC_BIT_TICK];
         rd_mux[`RTC_BIT_WRAP] = route_ff[`RTC_BIT_WRAP];
         rd_mux[`RTC_BIT_CMP0 +: N_CMP] = cmp_route;
      end else if (I_ADDR == `RTC_OFS_COUNT) begin
         rd_mux[CNT_W-1:0] = cnt_ff;
      end else if (I_ADDR == `RTC_OFS_PRESCALE) begin
         rd_mux[PRE_W-1:0] = pre_set_ff;
      end else if (cmp_val_page && (I_ADDR[3:2] < N_CMP)) begin
         rd_mux[CNT_W-1:0] = cmp_vals[I_ADDR[3:2]*CNT_W +: CNT_W];
      end
   end

   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         O_RDATA <= 32'h00000000;
         O_BUS_HOLD <= 1'b0;
         hold_ff <= 2'h0;
      end else if (I_CE) begin
         O_RDATA <= I_RD ? rd_mux : 32'h00000000;
         if (I_RD && (I_ADDR == `RTC_OFS_COUNT)) begin
            hold_ff <= `RTC_HOLD_CYCLES - 2'h1;
            O_BUS_HOLD <= 1'b1;
         end else if (hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
            O_BUS_HOLD <= 1'b1;
         end else begin
            O_BUS_HOLD <= 1'b0;
         end
      end
   end
endmodule // rtc_counter

// ### rtc_counter_sva.sv
`timescale 1ns/1ps
module rtc_counter_sva #(
   parameter N_CMP = 4
) (
   input wire I_MCLK,
   input wire I_RST,
   input wire I_SLOW_CLK,
   input wire [11:0] I_ADDR,
   input wire I_RD,
   input wire [31:0] O_RDATA,
   input wire O_BUS_HOLD,
   input wire O_EVT_TICK,
   input wire O_EVT_WRAP,
   input wire [N_CMP-1:0] O_EVT_CMP,
   input wire O_CLK_REQ,
   input wire O_RUNNING
);
   reg slow_prev_ff;
   wire slow_rise = I_SLOW_CLK & ~slow_prev_ff;
   wire any_ev = O_EVT_TICK | O_EVT_WRAP | (|O_EVT_CMP);
   always @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) slow_prev_ff <= 1'b0;
      else slow_prev_ff <= I_SLOW_CLK;
   end
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (I_RST);
   a_req_from_event: assert property (O_CLK_REQ |-> any_ev)
      else $error("clock request without routed event");
   a_event_requests: assert property (any_ev |-> O_CLK_REQ)
      else $error("routed event without clock request");
   a_tick_on_rise: assert property (O_EVT_TICK |-> $past(slow_rise) || $past(slow_rise, 2))
      else $error("tick not after slow rise");
   a_tick_one_pulse: assert property (O_EVT_TICK |=> !O_EVT_TICK [*3])
      else $error("tick faster than slow clock");
   a_halt_quiet: assert property (!O_RUNNING ##1 !O_RUNNING |-> !O_EVT_TICK && !O_EVT_WRAP)
      else $error("event while stopped");
   a_run_on_rise: assert property ($changed(O_RUNNING)
      |-> $past(slow_rise) || $past(slow_rise, 2) || $past(slow_rise, 3))
      else $error("run state changed off slow rise");
   a_count_width: assert property ($past(I_RD) && $past(I_ADDR) == 12'h504
      |-> O_RDATA[31:24] == 8'h0)
      else $error("count wider than 24 bits");
   a_hold_three: assert property (I_RD && I_ADDR == 12'h504 |=> O_BUS_HOLD [*3])
      else $error("count read hold too short");
   a_hold_cause: assert property ($rose(O_BUS_HOLD) |-> $past(I_RD) && $past(I_ADDR) == 12'h504)
      else $error("bus hold without count read");
   a_wrap_on_rise: assert property (O_EVT_WRAP |-> $past(slow_rise) || $past(slow_rise, 2))
      else $error("wrap not after slow rise");
   c_tick: cover property (O_EVT_TICK);
   c_wrap: cover property (O_EVT_WRAP);
   c_cmp: cover property (O_EVT_CMP[0]);
   c_hold: cover property ($rose(O_BUS_HOLD));
endmodule // rtc_counter_sva

bind rtc_counter rtc_counter_sva #(.N_CMP(N_CMP)) i_rtc_counter_sva (.I_MCLK(I_MCLK),
   .I_RST(I_RST), .I_SLOW_CLK(I_SLOW_CLK), .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .O_BUS_HOLD(O_BUS_HOLD), .O_EVT_TICK(O_EVT_TICK), .O_EVT_WRAP(O_EVT_WRAP),
   .O_EVT_CMP(O_EVT_CMP), .O_CLK_REQ(O_CLK_REQ), .O_RUNNING(O_RUNNING));

// ### rtc_counter_tb.sv
`timescale 1ns/1ps
module rtc_counter_tb;
   logic I_MCLK = 0, I_RST = 1, I_CE = 1, I_SLOW_CLK = 0, I_WR = 0, I_RD = 0;
   logic [11:0] I_ADDR = 12'h0;
   logic [31:0] I_WDATA = 32'h0;
   wire [31:0] O_RDATA;
   wire O_BUS_HOLD, O_EVT_TICK, O_EVT_WRAP, O_CLK_REQ, O_RUNNING;
   wire [3:0] O_EVT_CMP;
   int mismatches = 0, compares = 0, n;
   logic [1:0] sdiv = 2'h0;
   logic [31:0] rv, rv2;
   rtc_counter #(.N_CMP(4)) i_rtc_counter (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CE(I_CE),
      .I_SLOW_CLK(I_SLOW_CLK), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
      .O_RDATA(O_RDATA), .O_BUS_HOLD(O_BUS_HOLD), .O_EVT_TICK(O_EVT_TICK),
      .O_EVT_WRAP(O_EVT_WRAP), .O_EVT_CMP(O_EVT_CMP), .O_CLK_REQ(O_CLK_REQ),
      .O_RUNNING(O_RUNNING));
   initial begin
      forever #25 I_MCLK = ~I_MCLK;
   end
   // Shortened slow clock, 8 fast cycles a period, running before first use
   always @(posedge I_MCLK) begin
      sdiv <= sdiv + 2'h1;
      if (sdiv == 2'h3) I_SLOW_CLK <= ~I_SLOW_CLK;
   end
   task complete_run;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge I_MCLK);
      I_WR <= 1'b1; I_ADDR <= a; I_WDATA <= d;
      @(posedge I_MCLK);
      I_WR <= 1'b0;
   endtask
   task rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge I_MCLK);
      I_RD <= 1'b1; I_ADDR <= a;
      @(posedge I_MCLK);
      I_RD <= 1'b0;
      #1 d = O_RDATA;
   endtask
   // Counts cycles until the chosen event, or returns the limit if none came
   task wait_ev(input int sel, input int lim, output int k);
      k = 0;
      while (k < lim) begin
         @(posedge I_MCLK);
         #1 k++;
         if (sel == 0 ? O_EVT_TICK : sel == 1 ? O_EVT_WRAP : O_EVT_CMP[0]) break;
      end
   endtask
   task t_reset;
      rd(12'h340, rv); chk(rv, 32'h0);
      rd(12'h504, rv); chk(rv, 32'h0);
      chk(O_BUS_HOLD, 1);
      rd(12'h200, rv); chk(rv, 32'h0);
   endtask
   task t_rate;
      wr(12'h508, 32'h2);
      wr(12'h344, 32'h10003);
      wr(12'h000, 32'h1);
      wait_ev(0, 400, n); chk(O_CLK_REQ, 1);
      wait_ev(0, 100, n); chk(n, 24);
      wr(12'h508, 32'h5);
      rd(12'h508, rv); chk(rv, 32'h2);
   endtask
   // Enable low for whole slow periods delays the next tick by exactly that span
   task t_freeze;
      wait_ev(0, 100, n);
      @(posedge I_MCLK);
      I_CE <= 1'b0;
      repeat (64) @(posedge I_MCLK);
      I_CE <= 1'b1;
      wait_ev(0, 100, n); chk(n, 23);
   endtask
   task t_compare;
      rd(12'h504, rv);
      wr(12'h540, rv + 32'h4);
      wait_ev(2, 200, n);
      rd(12'h504, rv2); chk(rv2, rv + 32'h4);
      rd(12'h140, rv2); chk(rv2, 32'h1);
      rd(12'h504, rv);
      wr(12'h540, rv + 32'h6);
      wr(12'h540, rv + 32'h28);
      wait_ev(2, 200, n); chk(n, 200);
   endtask
   task t_wrap;
      wr(12'h00c, 32'h1);
      wait_ev(1, 800, n); chk(n >= 380 && n <= 410, 1);
      rd(12'h504, rv); chk(rv, 32'h0);
      rd(12'h104, rv); chk(rv, 32'h1);
   endtask
   // Routing register forms and software flag clears
   task t_route;
      wr(12'h348, 32'h2);
      rd(12'h340, rv); chk(rv, 32'h10001);
      wr(12'h340, 32'hffff0001);
      rd(12'h344, rv); chk(rv, 32'hf0001);
      wr(12'h104, 32'h0);
      rd(12'h104, rv); chk(rv, 32'h0);
      wr(12'h140, 32'h0);
      rd(12'h140, rv); chk(rv, 32'h0);
   endtask
   task t_stop_clear;
      wr(12'h004, 32'h1);
      repeat (40) @(posedge I_MCLK);
      rd(12'h504, rv);
      repeat (60) @(posedge I_MCLK);
      rd(12'h504, rv2); chk(rv2, rv);
      chk(O_RUNNING, 0);
      wr(12'h540, 32'h0);
      wr(12'h008, 32'h1);
      wait_ev(2, 60, n); chk(n, 60);
      rd(12'h504, rv); chk(rv, 32'h0);
      wr(12'h000, 32'h1);
      wait_ev(2, 100, n); chk(n, 100);
      chk(O_RUNNING, 1);
   endtask
   initial begin
      #400000;
      mismatches++;
      complete_run;
   end
   initial begin
      repeat (16) @(posedge I_MCLK);
      I_RST <= 1'b0;
      t_reset;
      t_rate;
      t_freeze;
      t_compare;
      t_wrap;
      t_route;
      t_stop_clear;
      complete_run;
   end
endmodule // rtc_counter_tb
